// File: mmec_top.sv
// memory map decoder and eeprom program control, apb slave
// assumes apb master on the same 40 mhz clock; paddr is a byte address
`default_nettype none

module mmec_top
    import mmec_pkg::*;
#(
    parameter logic [7:0] ROM_FILL = 8'h00  // arbitrary content for unmodelled rom
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             charge_pump_on,
    output logic             program_voltage_on,
    output logic             rc_osc_select
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [13:0]  cpu_addr;
    mmec_region_t region;
    logic         in_stack;
    logic         setup;
    logic         access;
    logic [7:0]   ctrl_q;
    logic [7:0]   ctrl_d;
    logic [7:0]   ram_q [256];
    mmec_latch_t  latch_q;
    logic [7:0]   ee_rd;
    logic         pgm_q;
    mmec_region_t dec_region;
    logic         addr_hi_ok;
    logic         op_go;
    logic         wr_ctrl;
    logic         wr_ram;
    logic         wr_ee;

    // only the low 14 bits reach the decoder; anything above the 16k map
    // is forced to the unmapped region so that it can neither alias into
    // ram nor touch the control register, and it answers with pslverr
    assign cpu_addr   = paddr[ADDR_W-1:0];
    assign addr_hi_ok = (paddr[31:ADDR_W] == 18'h0_0000);
    assign setup      = psel && !penable;
    assign access     = psel && penable && pready;

    mmec_decode u_decode (
        .addr     (cpu_addr),
        .region   (dec_region),
        .in_stack (in_stack)
    );

    // region as the rest of the block sees it
    assign region = addr_hi_ok ? dec_region : MMEC_RGN_NONE;

    // ----------------------------------------------------------------
    // write strobes, each true only at the edge that ends the access
    // ----------------------------------------------------------------
    assign wr_ctrl = access && pwrite && region == MMEC_RGN_REG
                     && cpu_addr == EE_CTRL_ADDR;
    assign wr_ram  = access && pwrite && region == MMEC_RGN_RAM;
    assign wr_ee   = access && pwrite && region == MMEC_RGN_EE;

    // ram offset from its base; the region check keeps it inside 0..255
    function automatic logic [7:0] ram_index(input logic [13:0] a);
        logic [13:0] off;
        off = a - RAM_BASE;
        ram_index = off[7:0];
    endfunction : ram_index

    // ----------------------------------------------------------------
    // apb handshake: no wait state, pready pulses in the first access-phase cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) pready <= 1'b0;
        else        pready <= setup;
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = pwdata[7:0] & CTRL_MASK;
            // power bit only takes a one when latch was already set
            if (!ctrl_q[BIT_LATCH]) ctrl_d[BIT_PWR] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) ctrl_q <= CTRL_RESET;
        else        ctrl_q <= ctrl_d;
    end

    // ----------------------------------------------------------------
    // program latch: captured by array writes while latch bit is set
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            latch_q <= '0;
        end else if (!ctrl_q[BIT_LATCH]) begin
            latch_q <= '0;
        end else if (wr_ee) begin
            latch_q.valid <= 1'b1;
            latch_q.addr  <= cpu_addr[7:0];
            latch_q.data  <= pwdata[7:0];
        end
    end

    // rising edge of the power bit fires one operation
    always_ff @(posedge clock) begin
        if (!rst_n) pgm_q <= 1'b0;
        else        pgm_q <= ctrl_q[BIT_PWR];
    end

    // one operation per rising edge of the power bit, only while the latch
    // bit still holds the captured request and the pump runs; a write that
    // drops the latch bit while raising power fires nothing
    assign op_go = ctrl_q[BIT_PWR] && !pgm_q && ctrl_q[BIT_LATCH] && latch_q.valid
                   && ctrl_q[BIT_PUMP];

    mmec_ee_array u_array (
        .clock   (clock),
        .rst_n   (rst_n),
        .op_go   (op_go),
        .op      (mmec_op_t'({ctrl_q[BIT_ERS_HI], ctrl_q[BIT_ERS_LO]})),
        .op_addr (latch_q.addr),
        .op_data (latch_q.data),
        .rd_addr (cpu_addr[7:0]),
        .rd_data (ee_rd)
    );

    // ----------------------------------------------------------------
    // ram; rom regions ignore writes
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (wr_ram)
            ram_q[ram_index(cpu_addr)] <= pwdata[7:0];
    end

    // ----------------------------------------------------------------
    // read data and error response
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata  <= RDATA_ZERO;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= RDATA_ZERO;
            pslverr <= (region == MMEC_RGN_NONE) || (paddr[31:14] != '0);
            if (!pwrite) begin
                case (region)
                    MMEC_RGN_REG:
                        // unassigned registers read zero, no side effects
                        if (cpu_addr == EE_CTRL_ADDR) prdata[7:0] <= ctrl_d;
                    MMEC_RGN_RAM:  prdata[7:0] <= ram_q[ram_index(cpu_addr)];
                    MMEC_RGN_EE:
                        // reads inhibited after a latched write
                        if (!(ctrl_q[BIT_LATCH] && latch_q.valid))
                            prdata[7:0] <= ee_rd;
                    MMEC_RGN_ROM, MMEC_RGN_BOOT, MMEC_RGN_VEC:
                        prdata[7:0] <= ROM_FILL;
                    default: prdata <= RDATA_ZERO;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // pump and power outputs
    // ----------------------------------------------------------------
    // pump follows its enable bit from the edge at which the write lands
    always_ff @(posedge clock) begin
        if (!rst_n) charge_pump_on <= 1'b0;
        else        charge_pump_on <= ctrl_d[BIT_PUMP];
    end

    // the pump alone never reaches the array: the power bit gates it
    always_ff @(posedge clock) begin
        if (!rst_n) program_voltage_on <= 1'b0;
        else        program_voltage_on <= ctrl_d[BIT_PUMP] && ctrl_d[BIT_PWR];
    end

    // clock source choice for the cells, passed through untouched
    always_ff @(posedge clock) begin
        if (!rst_n) rc_osc_select <= 1'b0;
        else        rc_osc_select <= ctrl_d[BIT_RC];
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_power_needs_latch: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(ctrl_q[BIT_PWR]) |-> $past(ctrl_q[BIT_LATCH]))
        else $error("power bit set without latch");
    chk_voltage_gated: assert property (@(posedge clock) disable iff (!rst_n)
        program_voltage_on |-> ctrl_q[BIT_PWR] && ctrl_q[BIT_PUMP])
        else $error("voltage on without power bit");
    chk_pump_follows: assert property (@(posedge clock) disable iff (!rst_n)
        charge_pump_on == ctrl_q[BIT_PUMP])
        else $error("pump output mismatch");
    chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl_q & ~CTRL_MASK) == 8'h00)
        else $error("reserved control bits set");
    chk_ctrl_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ctrl |=>
            ctrl_q[BIT_PUMP] == $past(pwdata[BIT_PUMP]))
        else $error("control write lost");
    chk_apb_wait: assert property (@(posedge clock) disable iff (!rst_n)
        setup |=> pready ##1 !pready)
        else $error("pready timing wrong");
    chk_read_inhibit: assert property (@(posedge clock) disable iff (!rst_n)
        setup && !pwrite && region == MMEC_RGN_EE && ctrl_q[BIT_LATCH] && latch_q.valid
            |=> prdata == RDATA_ZERO)
        else $error("array read not inhibited");
    chk_decode_stack: assert property (@(posedge clock) disable iff (!rst_n)
        in_stack |-> dec_region == MMEC_RGN_RAM)
        else $error("stack outside ram");
    chk_latch_capture: assert property (@(posedge clock) disable iff (!rst_n)
        access && pwrite && region == MMEC_RGN_EE && ctrl_q[BIT_LATCH]
            |=> latch_q.valid && latch_q.addr == $past(cpu_addr[7:0]))
        else $error("latch capture missed");

    // reset leaves the register and every output low, whatever came before
    chk_reset_state: assert property (@(posedge clock)
        !rst_n |=> ctrl_q == CTRL_RESET && !pready && !charge_pump_on
            && !program_voltage_on && !rc_osc_select)
        else $error("state not cleared by reset");
    chk_rc_follows: assert property (@(posedge clock) disable iff (!rst_n)
        rc_osc_select == ctrl_q[BIT_RC])
        else $error("rc select output mismatch");

    // ----------------------------------------------------------------
    // checks on the programming sequence
    // ----------------------------------------------------------------
    chk_latch_drop: assert property (@(posedge clock) disable iff (!rst_n)
        !ctrl_q[BIT_LATCH] |=> !latch_q.valid)
        else $error("captured request survives latch clear");
    chk_op_gated: assert property (@(posedge clock) disable iff (!rst_n)
        op_go |-> ctrl_q[BIT_LATCH] && ctrl_q[BIT_PUMP] && ctrl_q[BIT_PWR])
        else $error("array operation without power");
    chk_op_single: assert property (@(posedge clock) disable iff (!rst_n)
        op_go |=> !op_go)
        else $error("array operation repeated");

    // ----------------------------------------------------------------
    // checks on the bus answer and the ram decode
    // ----------------------------------------------------------------
    chk_err_unmapped: assert property (@(posedge clock) disable iff (!rst_n)
        setup && region == MMEC_RGN_NONE |=> pslverr)
        else $error("unmapped access not flagged");
    chk_err_mapped: assert property (@(posedge clock) disable iff (!rst_n)
        setup && region != MMEC_RGN_NONE |=> !pslverr)
        else $error("mapped access flagged");
    chk_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n)
        setup && region == MMEC_RGN_NONE |=> prdata == RDATA_ZERO)
        else $error("unmapped read not zero");
    chk_rom_fill: assert property (@(posedge clock) disable iff (!rst_n)
        setup && !pwrite && (region == MMEC_RGN_ROM || region == MMEC_RGN_BOOT
            || region == MMEC_RGN_VEC) |=> prdata[7:0] == ROM_FILL)
        else $error("rom read value wrong");
    chk_ctrl_readback: assert property (@(posedge clock) disable iff (!rst_n)
        setup && !pwrite && region == MMEC_RGN_REG && cpu_addr == EE_CTRL_ADDR
            |=> prdata[7:0] == ctrl_q)
        else $error("control read value wrong");
    chk_prdata_upper: assert property (@(posedge clock) disable iff (!rst_n)
        pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_ram_bounds: assert property (@(posedge clock) disable iff (!rst_n)
        region == MMEC_RGN_RAM |-> cpu_addr >= RAM_BASE && cpu_addr <= RAM_TOP)
        else $error("ram decoded outside its range");

endmodule : mmec_top

`default_nettype wire

// File: mmec_pkg.sv
// package for the memory map decoder and eeprom program control block
// assumes a 16 kbyte cpu address space reached over apb with 32-bit data
`default_nettype none

package mmec_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W       = 14;
    localparam logic [13:0] REG_TOP      = 14'h003f;
    localparam logic [13:0] RAM_BASE     = 14'h0040;
    localparam logic [13:0] RAM_TOP      = 14'h013f;
    localparam logic [13:0] STACK_TOP    = 14'h00ff;
    localparam logic [13:0] STACK_BOTTOM = 14'h00c0;
    localparam logic [13:0] EE_BASE      = 14'h0200;
    localparam logic [13:0] EE_TOP       = 14'h02ff;
    localparam logic [13:0] ROM_BASE     = 14'h3000;
    localparam logic [13:0] ROM_TOP      = 14'h3eff;
    localparam logic [13:0] BOOT_BASE    = 14'h3f00;
    localparam logic [13:0] BOOT_TOP     = 14'h3fef;
    localparam logic [13:0] VEC_BASE     = 14'h3ff0;
    localparam logic [13:0] VEC_TOP      = 14'h3fff;
    localparam logic [13:0] EE_CTRL_ADDR = 14'h001c;

    // ----------------------------------------------------------------
    // control register layout
    // ----------------------------------------------------------------
    localparam int unsigned BIT_PUMP     = 6;
    localparam int unsigned BIT_ERS_HI   = 4;
    localparam int unsigned BIT_ERS_LO   = 3;
    localparam int unsigned BIT_LATCH    = 2;
    localparam int unsigned BIT_RC       = 1;
    localparam int unsigned BIT_PWR      = 0;
    localparam logic [7:0]  CTRL_MASK    = 8'h5f;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    typedef enum logic [2:0] {
        MMEC_RGN_NONE, MMEC_RGN_REG, MMEC_RGN_RAM, MMEC_RGN_EE,
        MMEC_RGN_ROM, MMEC_RGN_BOOT, MMEC_RGN_VEC
    } mmec_region_t;

    typedef enum logic [1:0] {
        MMEC_OP_PROG, MMEC_OP_ERASE_BYTE, MMEC_OP_ERASE_BLOCK, MMEC_OP_ERASE_ALL
    } mmec_op_t;

    // captured programming request
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } mmec_latch_t;

endpackage : mmec_pkg

`default_nettype wire

// File: mmec_decode.sv
// address region decoder for the 16 kbyte map
// assumes a byte address already reduced to 14 bits
`default_nettype none

module mmec_decode
    import mmec_pkg::*;
(
    input  wire logic [13:0] addr,
    output mmec_region_t     region,
    output logic             in_stack
);

    function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo,
                                      input logic [13:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // ----------------------------------------------------------------
    // region select
    // ----------------------------------------------------------------
    always_comb begin
        if (addr <= REG_TOP)                        region = MMEC_RGN_REG;
        else if (in_range(addr, RAM_BASE, RAM_TOP))   region = MMEC_RGN_RAM;
        else if (in_range(addr, EE_BASE, EE_TOP))     region = MMEC_RGN_EE;
        else if (in_range(addr, ROM_BASE, ROM_TOP))   region = MMEC_RGN_ROM;
        else if (in_range(addr, BOOT_BASE, BOOT_TOP)) region = MMEC_RGN_BOOT;
        else if (in_range(addr, VEC_BASE, VEC_TOP))   region = MMEC_RGN_VEC;
        else                                          region = MMEC_RGN_NONE;
    end

    // stack window inside ram
    assign in_stack = in_range(addr, STACK_BOTTOM, STACK_TOP);

endmodule : mmec_decode

`default_nettype wire

// File: mmec_ee_array.sv
// 256 byte eeprom cell array with and-programming and erase modes
// assumes a single strobe per operation from the control block
`default_nettype none

module mmec_ee_array
    import mmec_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       op_go,
    input  wire mmec_op_t   op,
    input  wire logic [7:0] op_addr,
    input  wire logic [7:0] op_data,
    input  wire logic [7:0] rd_addr,
    output logic [7:0]      rd_data
);

    logic [7:0] cell_q [256];

    // ----------------------------------------------------------------
    // cell update; cells are nonvolatile so reset leaves them
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst_n && op_go) begin
            for (int i = 0; i < 256; i++) begin
                case (op)
                    MMEC_OP_PROG:
                        if (i == int'(op_addr))
                            cell_q[i] <= cell_q[i] & op_data;
                    MMEC_OP_ERASE_BYTE:
                        if (i == int'(op_addr))
                            cell_q[i] <= ERASED_BYTE;
                    MMEC_OP_ERASE_BLOCK:
                        if (i[7:6] == op_addr[7:6])
                            cell_q[i] <= ERASED_BYTE;
                    MMEC_OP_ERASE_ALL:
                        cell_q[i] <= ERASED_BYTE;
                    default: ;
                endcase
            end
        end
    end

    assign rd_data = cell_q[rd_addr];

endmodule : mmec_ee_array

`default_nettype wire

// File: mmec_cpu_model.sv
// apb master standing in for the cpu core on the internal bus
// assumes xfer is entered right after a rising clock edge
`default_nettype none

module mmec_cpu_model (
    input  wire logic   clock,
    input  wire logic   pready,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // bus idle at time zero
    // ------------------------------------------------------------
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h0000_0000;
        pwdata  = 32'h0000_0000;
    end

    // setup, access until pready, then one idle edge so that no
    // signal is assigned twice in one time step; stale data inverted
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~pwdata;
        @(posedge clock);
    endtask : xfer
endmodule : mmec_cpu_model

`default_nettype wire

// File: memory_map_eeprom_control_test.sv
// self-checking bench for the memory map and eeprom control block
// assumes the cpu model speaks apb; eeprom cells start unknown
`default_nettype none

module memory_map_eeprom_control_test
    import mmec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] data;
        logic        err;
        logic        rd;
    } mmec_note_t;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic        pump_on, volt_on, rc_sel;
    logic [7:0]  ee_m [256];
    logic [17:0] hi_q = 18'h0_0000;
    mmec_note_t  notes [$];
    mmec_note_t  nt;
    int          miscompares = 0;
    int          n_checks = 0;

    always #12.5 clock = ~clock;

    mmec_cpu_model cpu_u (.clock(clock), .pready(pready), .psel(psel), .penable(penable),
                          .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    mmec_top dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
                    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
                    .prdata(prdata), .pslverr(pslverr), .charge_pump_on(pump_on),
                    .program_voltage_on(volt_on), .rc_osc_select(rc_sel));

    // ------------------------------------------------------------
    // comparison, notes and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // note what the bus answer must be, then run the transfer
    task automatic acc(input logic wr, input logic [13:0] a, input logic [7:0] d,
                       input logic [7:0] exp, input logic err);
        notes.push_back('{{24'h00_0000, exp}, err, !wr});
        cpu_u.xfer(wr, {hi_q, a}, d);
    endtask : acc

    // pump, voltage and rc select levels in that order
    task automatic outs(input logic [2:0] exp);
        check({29'h0000_0000, pump_on, volt_on, rc_sel}, {29'h0000_0000, exp});
    endtask : outs

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // answers are sampled at the edge that ends the access phase
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            check({31'h0000_0000, pslverr}, {31'h0000_0000, nt.err});
            if (nt.rd) begin
                check(prdata, nt.data);
            end
        end
    end

    // ------------------------------------------------------------
    // eeprom sequences, mirrored in a cell model
    // ------------------------------------------------------------
    task automatic ee_op(input logic [1:0] md, input logic [7:0] a, input logic [7:0] d);
        logic [7:0]  c;
        logic [13:0] ea;
        c = 8'h44 | {3'h0, md, 3'h0};
        ea = EE_BASE | {6'h00, a};
        acc(1'b1, EE_CTRL_ADDR, c, 8'h00, 1'b0);
        outs(3'h4);
        acc(1'b1, ea, d, 8'h00, 1'b0);
        acc(1'b0, ea, 8'h00, 8'h00, 1'b0);
        acc(1'b1, EE_CTRL_ADDR, c | 8'h01, 8'h00, 1'b0);
        acc(1'b0, EE_CTRL_ADDR, 8'h00, c | 8'h01, 1'b0);
        outs(3'h6);
        acc(1'b1, EE_CTRL_ADDR, c, 8'h00, 1'b0);
        outs(3'h4);
        acc(1'b1, EE_CTRL_ADDR, 8'h00, 8'h00, 1'b0);
        outs(3'h0);
        case (md)
            2'h0: ee_m[a] = ee_m[a] & d;
            2'h1: ee_m[a] = ERASED_BYTE;
            2'h2: for (int i = 0; i < 64; i++) ee_m[{a[7:6], i[5:0]}] = ERASED_BYTE;
            default: foreach (ee_m[i]) ee_m[i] = ERASED_BYTE;
        endcase
    endtask : ee_op

    task automatic ee_verify;
        for (int i = 0; i < 256; i++) begin
            acc(1'b0, EE_BASE | {6'h00, i[7:0]}, 8'h00, ee_m[i], 1'b0);
        end
    endtask : ee_verify

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict();
    end

    initial begin
        logic [7:0]  r;
        logic [7:0]  rv [4];
        logic [13:0] ram_a [4];
        logic [13:0] ro_a [12];
        ram_a = '{RAM_BASE, STACK_BOTTOM, STACK_TOP, RAM_TOP};
        ro_a = '{ROM_BASE, ROM_TOP, BOOT_BASE, BOOT_TOP, VEC_BASE, VEC_TOP, 14'h001d,
                 REG_TOP, 14'h0140, 14'h01ff, 14'h0300, 14'h2fff};
        void'($urandom(12));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        outs(3'h0);
        acc(1'b0, EE_CTRL_ADDR, 8'h00, CTRL_RESET, 1'b0);
        // reserved bits and power without latch must not stick
        acc(1'b1, EE_CTRL_ADDR, 8'hff, 8'h00, 1'b0);
        acc(1'b0, EE_CTRL_ADDR, 8'h00, 8'h5e, 1'b0);
        outs(3'h5);
        acc(1'b1, EE_CTRL_ADDR, 8'h00, 8'h00, 1'b0);
        outs(3'h0);
        foreach (ram_a[k]) begin
            rv[k] = 8'($urandom());
            acc(1'b1, ram_a[k], rv[k], 8'h00, 1'b0);
        end
        foreach (ram_a[k]) begin
            acc(1'b0, ram_a[k], 8'h00, rv[k], 1'b0);
        end
        // an address above the 16k map is refused and must not alias into ram
        hi_q = 18'($urandom()) | 18'h0_0001;
        acc(1'b1, RAM_BASE, ~rv[0], 8'h00, 1'b1);
        acc(1'b0, RAM_BASE, 8'h00, 8'h00, 1'b1);
        hi_q = 18'h0_0000;
        acc(1'b0, RAM_BASE, 8'h00, rv[0], 1'b0);
        // read-only and unassigned places: writes dropped, reads zero
        foreach (ro_a[k]) begin
            acc(1'b1, ro_a[k], 8'ha5, 8'h00, k > 7);
            acc(1'b0, ro_a[k], 8'h00, 8'h00, k > 7);
        end
        // a second reset in mid-run must drop pump, latch and rc settings
        acc(1'b1, EE_CTRL_ADDR, 8'h46, 8'h00, 1'b0);
        outs(3'h5);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        outs(3'h0);
        acc(1'b0, EE_CTRL_ADDR, 8'h00, CTRL_RESET, 1'b0);
        ee_op(2'h3, 8'h00, 8'h00);
        ee_verify();
        r = 8'($urandom());
        ee_op(2'h0, 8'h10, r);
        ee_op(2'h0, 8'h10, 8'($urandom()));
        ee_op(2'h0, 8'h40, r);
        ee_op(2'h0, 8'h7f, 8'h00);
        ee_op(2'h0, 8'h80, 8'h00);
        ee_op(2'h0, 8'h3f, 8'h00);
        ee_op(2'h2, 8'h5a, 8'h00);
        ee_op(2'h1, 8'h10, 8'h00);
        ee_verify();
        print_verdict();
    end
endmodule : memory_map_eeprom_control_test

`default_nettype wire
